// ===== core/crs_defines.vh
// constants for the cpu register set: indices, status bit positions, constants
`ifndef CRS_DEFINES_VH
`define CRS_DEFINES_VH

// register indices
`define CRS_IDX_PC        4'h0
`define CRS_IDX_SP        4'h1
`define CRS_IDX_SR        4'h2
`define CRS_IDX_CG2       4'h3

// status_flags bit positions
`define CRS_SR_C          0
`define CRS_SR_Z          1
`define CRS_SR_N          2
`define CRS_SR_GIE        3
`define CRS_SR_PROCESSOR_OFF_BIT     4
`define CRS_SR_OSCILLATOR_OFF_BIT     5
`define CRS_SR_CLKGEN_CTRL_LO       6
`define CRS_SR_CLKGEN_CTRL_HI       7
`define CRS_SR_V          8

// implemented status bits, the rest read as zero
`define CRS_SR_MASK       16'h01ff
`define CRS_RESET_VAL     16'h0000

// source mode encodings
`define CRS_AS_REG        2'h0
`define CRS_AS_IDX        2'h1
`define CRS_AS_IND        2'h2
`define CRS_AS_INC        2'h3

// generated constants
`define CRS_K_ZERO        16'h0000
`define CRS_K_ONE         16'h0001
`define CRS_K_TWO         16'h0002
`define CRS_K_FOUR        16'h0004
`define CRS_K_EIGHT       16'h0008
`define CRS_K_ALLONES     16'hffff
`define CRS_WORD_STEP     16'h0002

// alu flag operation classes
`define CRS_FOP_NONE      3'h0
`define CRS_FOP_ADD       3'h1
`define CRS_FOP_SUB       3'h2
`define CRS_FOP_LOGIC     3'h3
`define CRS_FOP_NOTZ      3'h4

`endif

// ===== core/crs_flag_calc.v
// combinational status flag calculation for arithmetic and logic results
`timescale 1ns/1ns
`include "crs_defines.vh"

module crs_flag_calc (
  input  wire [2:0]  i_fop,
  input  wire        i_byte,
  input  wire [15:0] i_src,
  input  wire [15:0] i_dst,
  input  wire [15:0] i_res,
  input  wire        i_carry,
  output reg         o_v,
  output reg         o_n,
  output reg         o_z,
  output reg         o_c
);

  reg sa;
  reg da;
  reg ra;
  reg zr;

  // sign of operands and result at the operation width
  always @* begin
    sa  = i_byte ? i_src[7] : i_src[15];
    da  = i_byte ? i_dst[7] : i_dst[15];
    ra  = i_byte ? i_res[7] : i_res[15];
    zr  = i_byte ? (i_res[7:0] == 8'h00) : (i_res == 16'h0000);
    o_n = ra;
    o_z = zr;
    o_c = i_carry;
    o_v = 1'b0;
    case (i_fop)
      `CRS_FOP_ADD: begin
        o_v = (sa == da) && (ra != da);
      end
      `CRS_FOP_SUB: begin
        // dst - src: overflow when operand signs differ and result sign flips
        o_v = (sa != da) && (ra != da);
      end
      `CRS_FOP_NOTZ: begin
        o_c = ~zr;
      end
      default: begin
        o_v = 1'b0;
      end
    endcase
  end

endmodule

// ===== core/crs_register_set.v
// cpu register set: pc, sp, status flags, constant sources and working registers
`timescale 1ns/1ns
`include "crs_defines.vh"

module crs_register_set (
  input  wire        i_clk,
  input  wire        i_srst,
  // source read port from the decoder
  input  wire [3:0]  i_src_idx,
  input  wire [1:0]  i_src_mode,
  output reg  [15:0] o_src_data,
  output wire        o_src_const,
  // destination read port
  input  wire [3:0]  i_dst_idx,
  output reg  [15:0] o_dst_data,
  // register write port
  input  wire        i_wr_en,
  input  wire [3:0]  i_wr_idx,
  input  wire        i_wr_byte,
  input  wire [15:0] i_wr_data,
  // program counter advance in bytes
  input  wire        i_pc_adv,
  input  wire [2:0]  i_pc_len,
  // stack operations
  input  wire        i_push,
  input  wire        i_pop,
  input  wire [15:0] i_pop_data,
  input  wire [15:0] i_push_data,
  input  wire        i_call,
  input  wire [15:0] i_call_target,
  input  wire        i_irq_entry,
  input  wire [15:0] i_irq_vector,
  input  wire        i_return_from_interrupt_sr,
  input  wire        i_return_from_interrupt_pc,
  // flag update from the alu
  input  wire [2:0]  i_fop,
  input  wire        i_fbyte,
  input  wire [15:0] i_alu_src,
  input  wire [15:0] i_alu_dst,
  input  wire [15:0] i_alu_res,
  input  wire        i_alu_carry,
  // interrupt requests
  input  wire        i_irq_maskable,
  input  wire        i_irq_external,
  input  wire        i_nmi,
  // memory bus for stack and fetch
  output reg  [15:0] o_mem_addr,
  output reg  [15:0] o_mem_wdata,
  output reg         o_mem_we,
  output reg         o_mem_fetch,
  // register views and power state
  output wire [15:0] o_program_counter,
  output wire [15:0] o_stack_pointer,
  output wire [15:0] o_status_flags,
  output wire [1:0]  o_clkgen_state,
  output wire        o_osc_stopped,
  output wire        o_cpu_halted,
  output wire        o_irq_take
);

  reg  [15:0] regs_q [0:15];
  reg  [15:0] sp_dec;
  reg  [15:0] sr_d;
  wire [15:0] pc_q;
  wire [15:0] sp_q;
  wire [15:0] sr_q;
  wire        fv;
  wire        fn;
  wire        fz;
  wire        fc;
  wire        wake;

  assign pc_q = regs_q[`CRS_IDX_PC];
  assign sp_q = regs_q[`CRS_IDX_SP];
  assign sr_q = regs_q[`CRS_IDX_SR];

  ////////////////////////////////////////////////////////////////////////////
  // flag calculator
  crs_flag_calc u_flags (
    .i_fop   (i_fop),
    .i_byte  (i_fbyte),
    .i_src   (i_alu_src),
    .i_dst   (i_alu_dst),
    .i_res   (i_alu_res),
    .i_carry (i_alu_carry),
    .o_v     (fv),
    .o_n     (fn),
    .o_z     (fz),
    .o_c     (fc)
  );

  ////////////////////////////////////////////////////////////////////////////
  // power state and interrupt gating
  assign o_clkgen_state = {sr_q[`CRS_SR_CLKGEN_CTRL_HI], sr_q[`CRS_SR_CLKGEN_CTRL_LO]};
  // maskable requests pass only with global enable set
  assign o_irq_take = i_nmi | (i_irq_maskable & sr_q[`CRS_SR_GIE]);
  // oscillator-off wakes only by external enabled irq under gie, or nmi
  assign wake = sr_q[`CRS_SR_OSCILLATOR_OFF_BIT] ?
                (i_nmi | (i_irq_external & sr_q[`CRS_SR_GIE])) :
                o_irq_take;
  assign o_osc_stopped = sr_q[`CRS_SR_OSCILLATOR_OFF_BIT];
  assign o_cpu_halted  = sr_q[`CRS_SR_PROCESSOR_OFF_BIT] | sr_q[`CRS_SR_OSCILLATOR_OFF_BIT];

  assign o_program_counter = pc_q;
  assign o_stack_pointer   = sp_q;
  assign o_status_flags    = sr_q;
  assign o_src_const       = (i_src_idx == `CRS_IDX_CG2) ||
                             ((i_src_idx == `CRS_IDX_SR) && (i_src_mode != `CRS_AS_REG));

  ////////////////////////////////////////////////////////////////////////////
  // source operand mux with constant generation
  always @* begin
    o_src_data = regs_q[i_src_idx];
    if (i_src_idx == `CRS_IDX_SR) begin
      case (i_src_mode)
        `CRS_AS_REG: o_src_data = sr_q;
        `CRS_AS_IDX: o_src_data = `CRS_K_ZERO;
        `CRS_AS_IND: o_src_data = `CRS_K_FOUR;
        `CRS_AS_INC: o_src_data = `CRS_K_EIGHT;
        default:     o_src_data = sr_q;
      endcase
    end else if (i_src_idx == `CRS_IDX_CG2) begin
      case (i_src_mode)
        `CRS_AS_REG: o_src_data = `CRS_K_ZERO;
        `CRS_AS_IDX: o_src_data = `CRS_K_ONE;
        `CRS_AS_IND: o_src_data = `CRS_K_TWO;
        `CRS_AS_INC: o_src_data = `CRS_K_ALLONES;
        default:     o_src_data = `CRS_K_ZERO;
      endcase
    end
  end

  // destination read; register 3 reads as zero since it holds no state
  always @* begin
    o_dst_data = (i_dst_idx == `CRS_IDX_CG2) ? `CRS_K_ZERO : regs_q[i_dst_idx];
  end

  ////////////////////////////////////////////////////////////////////////////
  // stack bus: predecrement address on push, current top on pop
  always @* begin
    sp_dec      = sp_q - `CRS_WORD_STEP;
    o_mem_addr  = pc_q;
    o_mem_wdata = 16'h0000;
    o_mem_we    = 1'b0;
    o_mem_fetch = ~o_cpu_halted;
    if (i_irq_entry | i_call) begin
      o_mem_addr  = sp_dec;
      o_mem_wdata = pc_q;
      o_mem_we    = 1'b1;
      o_mem_fetch = 1'b0;
    end else if (i_push) begin
      o_mem_addr  = sp_dec;
      o_mem_wdata = i_push_data;
      o_mem_we    = 1'b1;
      o_mem_fetch = 1'b0;
    end else if (i_pop | i_return_from_interrupt_sr | i_return_from_interrupt_pc) begin
      o_mem_addr  = sp_q;
      o_mem_fetch = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // status register next value
  always @* begin
    sr_d = sr_q;
    if (i_fop != `CRS_FOP_NONE) begin
      sr_d[`CRS_SR_V] = fv;
      sr_d[`CRS_SR_N] = fn;
      sr_d[`CRS_SR_Z] = fz;
      sr_d[`CRS_SR_C] = fc;
    end
    if (i_wr_en && (i_wr_idx == `CRS_IDX_SR)) begin
      sr_d = i_wr_byte ? {8'h00, i_wr_data[7:0]} : i_wr_data;
    end
    if (i_return_from_interrupt_sr) begin
      sr_d = i_pop_data;
    end
    // wake clears the off bits so execution can resume
    if (wake && o_cpu_halted) begin
      sr_d[`CRS_SR_PROCESSOR_OFF_BIT] = 1'b0;
      sr_d[`CRS_SR_OSCILLATOR_OFF_BIT] = 1'b0;
    end
    if (i_irq_entry) begin
      sr_d[`CRS_SR_GIE] = 1'b0;
    end
    sr_d = sr_d & `CRS_SR_MASK;
  end

  ////////////////////////////////////////////////////////////////////////////
  // register file, one process per register
  genvar gi;
  generate
    for (gi = 0; gi < 16; gi = gi + 1) begin : g_reg
      wire wr_hit;
      wire [15:0] wr_val;
      assign wr_hit = i_wr_en && (i_wr_idx == gi);
      // byte writes clear the high byte
      assign wr_val = i_wr_byte ? {8'h00, i_wr_data[7:0]} : i_wr_data;
      if (gi == `CRS_IDX_PC) begin : g_pc
        always @(posedge i_clk) begin
          if (i_srst) begin
            regs_q[gi] <= `CRS_RESET_VAL;
          end else if (i_irq_entry) begin
            regs_q[gi] <= i_irq_vector & 16'hfffe;
          end else if (i_call) begin
            regs_q[gi] <= i_call_target & 16'hfffe;
          end else if (i_return_from_interrupt_pc) begin
            regs_q[gi] <= i_pop_data & 16'hfffe;
          end else if (wr_hit) begin
            regs_q[gi] <= wr_val & 16'hfffe;
          end else if (i_pc_adv && !o_cpu_halted) begin
            regs_q[gi] <= (pc_q + {13'h0000, i_pc_len[2:1], 1'b0});
          end
        end
      end else if (gi == `CRS_IDX_SP) begin : g_sp
        always @(posedge i_clk) begin
          if (i_srst) begin
            regs_q[gi] <= `CRS_RESET_VAL;
          end else if (i_pop && wr_hit) begin
            regs_q[gi] <= wr_val & 16'hfffe;
          end else if (i_irq_entry | i_call | i_push) begin
            regs_q[gi] <= sp_dec & 16'hfffe;
          end else if (i_pop | i_return_from_interrupt_sr | i_return_from_interrupt_pc) begin
            regs_q[gi] <= (sp_q + `CRS_WORD_STEP) & 16'hfffe;
          end else if (wr_hit) begin
            regs_q[gi] <= wr_val & 16'hfffe;
          end
        end
      end else if (gi == `CRS_IDX_SR) begin : g_sr
        always @(posedge i_clk) begin
          if (i_srst) begin
            regs_q[gi] <= `CRS_RESET_VAL;
          end else begin
            regs_q[gi] <= sr_d;
          end
        end
      end else if (gi == `CRS_IDX_CG2) begin : g_cg
        // constant source holds no state; writes are discarded
        always @(posedge i_clk) begin
          regs_q[gi] <= `CRS_K_ZERO;
        end
      end else begin : g_gen
        always @(posedge i_clk) begin
          if (i_srst) begin
            regs_q[gi] <= `CRS_RESET_VAL;
          end else if (wr_hit) begin
            regs_q[gi] <= wr_val;
          end
        end
      end
    end
  endgenerate

endmodule

// ===== bench/crs_mem_model.sv
// word memory standing on the register set bus
`timescale 1ns/1ns
module crs_mem_model (
  input  wire        i_clk,
  input  wire [15:0] i_addr,
  input  wire [15:0] i_wdata,
  input  wire        i_we,
  output wire [15:0] o_rdata
);
  logic [15:0] mem [32768];
  // unwritten words read the inverted index, never a stale value
  initial for (int k = 0; k < 32768; k++) mem[k] = ~16'(k);
  ////////////////
  // one flat word space, stores land on the edge
  always @(posedge i_clk) if (i_we) mem[i_addr[15:1]] <= i_wdata;
  assign o_rdata = mem[i_addr[15:1]];
endmodule

// ===== bench/crs_register_set_chk.sv
// concurrent checks on the register set ports
`timescale 1ns/1ns
module crs_register_set_chk (
  input wire        i_clk,
  input wire        i_srst,
  input wire [3:0]  i_src_idx,
  input wire [1:0]  i_src_mode,
  input wire [15:0] o_src_data,
  input wire        o_src_const,
  input wire        i_wr_en,
  input wire        i_push,
  input wire        i_pop,
  input wire        i_call,
  input wire        i_irq_entry,
  input wire        i_return_from_interrupt_sr,
  input wire        i_return_from_interrupt_pc,
  input wire [2:0]  i_fop,
  input wire        i_irq_maskable,
  input wire        i_nmi,
  input wire [15:0] o_mem_addr,
  input wire        o_mem_we,
  input wire [15:0] o_program_counter,
  input wire [15:0] o_stack_pointer,
  input wire [15:0] o_status_flags,
  input wire        o_irq_take
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_srst);
  // no competing register or stack traffic this cycle
  wire quiet = !i_irq_entry && !i_call && !i_wr_en && !i_return_from_interrupt_pc && !i_return_from_interrupt_sr;
  ////////////////
  pc_even_a: assert property (!o_program_counter[0]) else $error("pc odd");
  sp_even_a: assert property (!o_stack_pointer[0]) else $error("sp odd");
  push_predec_a: assert property (i_push && quiet
    |-> o_mem_we && o_mem_addr == o_stack_pointer - 16'h2
    ##1 o_stack_pointer == $past(o_stack_pointer) - 16'h2) else $error("push");
  pop_postinc_a: assert property (i_pop && !i_push && quiet
    |-> o_mem_addr == o_stack_pointer
    ##1 o_stack_pointer == $past(o_stack_pointer) + 16'h2) else $error("pop");
  irq_gie_a: assert property (i_irq_entry |=> !o_status_flags[3])
    else $error("gie kept");
  take_gate_a: assert property (
    o_irq_take == (i_nmi | i_irq_maskable & o_status_flags[3])) else $error("take");
  cg_three_a: assert property (i_src_idx == 4'h3 |-> o_src_const
    && o_src_data == (&i_src_mode ? 16'hffff : {14'h0, i_src_mode})) else $error("cg");
  flag_hold_a: assert property (i_fop == 3'h0 && quiet
    |=> $stable({o_status_flags[8], o_status_flags[2:0]})) else $error("flags");
endmodule
bind crs_register_set crs_register_set_chk i_chk (.*);

// ===== bench/tb.sv
// self-checking bench for the cpu register set
`timescale 1ns/1ns
module tb;
  logic        i_clk, i_srst, i_wr_en, i_wr_byte, i_pc_adv, i_push, i_pop, i_call, i_nmi;
  logic        i_irq_entry, i_return_from_interrupt_sr, i_return_from_interrupt_pc, i_fbyte, i_alu_carry, i_irq_maskable;
  logic        i_irq_external, o_src_const, o_mem_we, o_mem_fetch, o_osc_stopped;
  logic        o_cpu_halted, o_irq_take;
  logic [3:0]  i_src_idx, i_dst_idx, i_wr_idx;
  logic [1:0]  i_src_mode, o_clkgen_state;
  logic [2:0]  i_pc_len, i_fop;
  logic [15:0] i_wr_data, i_push_data, i_call_target, i_irq_vector, i_pop_data, x, y, m;
  logic [15:0] i_alu_src, i_alu_dst, i_alu_res, o_src_data, o_dst_data, o_mem_addr;
  logic [15:0] o_mem_wdata, o_program_counter, o_stack_pointer, o_status_flags;
  logic [15:0] kt [8] = '{16'h0, 16'h1, 16'h2, 16'hffff, 16'h0, 16'h0, 16'h4, 16'h8};
  int          fails, n_tests;
  crs_register_set i_dut (.*);
  crs_mem_model i_mem (.i_clk(i_clk), .i_addr(o_mem_addr), .i_wdata(o_mem_wdata),
                       .i_we(o_mem_we), .o_rdata(i_pop_data));
  ////////////////
  // clock, and a watchdog well past the hundred or so cycles needed
  initial begin
    i_clk = 1'b0;
    forever #2 i_clk = ~i_clk;
  end
  initial begin
    repeat (3000) @(posedge i_clk);
    fails++;
    summarize;
  end
  ////////////////
  // inputs move 1 ns after the edge so sampling never races
  task automatic tick;
    @(posedge i_clk);
    #1;
  endtask
  task automatic idle;
    {i_wr_en, i_wr_byte, i_pc_adv, i_push, i_pop, i_call, i_irq_entry, i_return_from_interrupt_sr} = '0;
    {i_return_from_interrupt_pc, i_fbyte, i_alu_carry, i_nmi, i_irq_maskable, i_irq_external, i_fop} = '0;
  endtask
  task automatic wr(input logic [3:0] idx, input logic [15:0] d, input logic b);
    {i_wr_en, i_wr_idx, i_wr_data, i_wr_byte} = {1'b1, idx, d, b};
    tick;
    i_wr_en = 1'b0;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic summarize;
    $display("fails=%0d n_tests=%0d", fails, n_tests);
    if (fails == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // expected {v, n, z, c}; op 4 loads carry with inverted zero
  function automatic logic [15:0] flg(input logic [2:0] op, input logic bm, c,
                                      input logic [15:0] s, d, r);
    logic sb, db, rb, z;
    sb = bm ? s[7] : s[15];
    db = bm ? d[7] : d[15];
    rb = bm ? r[7] : r[15];
    z = bm ? r[7:0] == 8'h0 : r == 16'h0;
    flg = {12'h0, op == 3'h1 ? sb == db && rb != sb : op == 3'h2 && sb != db && rb != db,
           rb, z,
           op == 3'h4 ? !z : c};
  endfunction
  ////////////////
  // main sequence
  initial begin
    void'($urandom(32'hdb4cf812));
    {fails, n_tests} = '0;
    i_srst = 1'b1;
    idle;
    {i_src_idx, i_src_mode, i_dst_idx, i_wr_idx, i_pc_len, i_wr_data, i_push_data} = '0;
    {i_call_target, i_irq_vector, i_alu_src, i_alu_dst, i_alu_res} = '0;
    repeat (16) tick;
    i_srst = 1'b0;
    chk(o_program_counter | o_stack_pointer | o_status_flags, 16'h0);
    // constants while the status word is still zero
    for (int k = 0; k < 8; k++) begin
      {i_src_idx, i_src_mode} = {k < 4 ? 4'h3 : 4'h2, 2'(k)};
      #1 chk(o_src_data, kt[k]);
      chk({15'h0, o_src_const}, {15'h0, k != 4});
    end
    // odd registers take byte writes, which clear the high byte
    for (int r = 4; r < 16; r++) begin
      y = 16'($urandom);
      x = r[0] ? {8'h0, y[7:0]} : y;
      wr(4'(r), y, r[0]);
      {i_dst_idx, i_src_idx, i_src_mode} = {4'(r), 4'(r), 2'h0};
      #1 chk(o_dst_data, x);
      chk(o_src_data, x);
    end
    wr(4'h3, 16'h1234, 1'b0);
    i_dst_idx = 4'h3;
    #1 chk(o_dst_data, 16'h0);
    for (int s = 0; s < 4; s++) begin
      wr(4'h2, {8'h0, 2'(s), 6'h0}, 1'b0);
      chk({14'h0, o_clkgen_state}, 16'(s));
    end
    wr(4'h2, 16'hffff, 1'b0);
    chk(o_status_flags, 16'h01ff);
    i_irq_maskable = 1'b1;
    tick;
    chk({15'h0, o_osc_stopped}, 16'h1);
    i_irq_external = 1'b1;
    tick;
    chk({14'h0, o_osc_stopped, o_cpu_halted}, 16'h0);
    {i_irq_maskable, i_irq_external} = 2'b00;
    wr(4'h2, 16'h0010, 1'b0);
    {i_pc_adv, i_pc_len} = {1'b1, 3'h2};
    tick;
    chk(o_program_counter, 16'h0);
    chk({15'h0, o_mem_fetch}, 16'h0);
    {i_pc_adv, i_nmi} = 2'b01;
    tick;
    i_nmi = 1'b0;
    chk({15'h0, o_cpu_halted}, 16'h0);
    // lengths 2, 4, 6 and an odd 3 whose low bit is dropped
    x = 16'h0;
    for (int k = 0; k < 4; k++) begin
      {i_pc_adv, i_pc_len} = {1'b1, 3'(k < 3 ? 2 * k + 2 : 3)};
      x = x + {13'h0, i_pc_len[2:1], 1'b0};
      tick;
      chk(o_program_counter, x);
    end
    i_pc_adv = 1'b0;
    wr(4'h1, 16'h0401, 1'b0);
    chk(o_stack_pointer, 16'h0400);
    y = 16'($urandom);
    {i_push, i_push_data} = {1'b1, y};
    tick;
    {i_push, i_pop} = 2'b01;
    chk(o_stack_pointer, 16'h03fe);
    #1 chk(i_pop_data, y);
    tick;
    chk(o_stack_pointer, 16'h0400);
    {i_pop, i_push, i_push_data} = {2'b01, 16'h03fe};
    tick;
    {i_push, i_pop, i_wr_en, i_wr_idx, i_wr_data} = {2'b01, 1'b1, 4'h1, 16'h03fe};
    tick;
    {i_pop, i_wr_en, i_call, i_call_target} = {3'b001, 16'h1235};
    chk(o_stack_pointer, 16'h03fe);
    tick;
    i_call = 1'b0;
    chk(o_program_counter, 16'h1234);
    wr(4'h2, 16'h0008, 1'b0);
    {i_irq_entry, i_irq_vector} = {1'b1, 16'h2000};
    tick;
    {i_irq_entry, i_push, i_push_data} = {2'b01, 16'h0008};
    chk({o_program_counter[15:1], o_status_flags[3]}, 16'h2000);
    tick;
    {i_push, i_return_from_interrupt_sr} = 2'b01;
    tick;
    {i_return_from_interrupt_sr, i_return_from_interrupt_pc} = 2'b01;
    chk(o_status_flags, 16'h0008);
    tick;
    i_return_from_interrupt_pc = 1'b0;
    chk(o_program_counter, 16'h1234);
    chk(o_stack_pointer, 16'h03fc);
    // first pass is the corner 8000h + 8000h: overflow and zero
    for (int k = 0; k < 40; k++) begin
      x = (k == 0) ? 16'h0 : 16'($urandom);
      {i_alu_src, i_alu_dst} = (k == 0) ? 32'h80008000 : $urandom;
      {i_alu_carry, i_fbyte} = x[1:0];
      i_fop = 3'(x[3:2]) + 3'h1;
      i_alu_res = (i_fop == 3'h2) ? i_alu_dst - i_alu_src : i_alu_dst + i_alu_src;
      m = {12'h0, i_fop != 3'h4, 3'h7};
      y = flg(i_fop, i_fbyte, i_alu_carry, i_alu_src, i_alu_dst, i_alu_res) & m;
      tick;
      x = {12'h0, o_status_flags[8], o_status_flags[2:0]} & m;
      chk(x, y);
    end
    i_fop = 3'h0;
    repeat (2) tick;
    summarize;
  end
endmodule
